// ==== common/uart_rx_pkg.sv ====
`default_nettype none
package uart_rx_pkg;

	// ========================================
	// clock and bit timing
	localparam int unsigned CLK_HZ = 200_000_000;
	localparam int TIMER_W = 32;
	localparam int BITS_PER_FRAME = 9;
	localparam logic [3:0] FRAME_COUNT = 4'h9;
	localparam logic [3:0] BAUD_SEL_MASK = 4'hf;
	// bit periods in mclk cycles; entry zero samples every cycle
	localparam logic [31:0] BIT_PERIOD_TABLE [16] = '{
		32'h0, 32'(CLK_HZ / 50), 32'(CLK_HZ / 75), 32'(CLK_HZ / 110),
		32'(CLK_HZ / 135), 32'(CLK_HZ / 150), 32'(CLK_HZ / 300), 32'(CLK_HZ / 600),
		32'(CLK_HZ / 1200), 32'(CLK_HZ / 1800), 32'(CLK_HZ / 2400), 32'(CLK_HZ / 3600),
		32'(CLK_HZ / 4800), 32'(CLK_HZ / 7200), 32'(CLK_HZ / 9600), 32'(CLK_HZ / 19200)
	};

	// ========================================
	// register byte addresses
	localparam logic [7:0] ADDR_PORT_COMMAND = 8'h00;
	localparam logic [7:0] ADDR_LINE_SETTINGS = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_RX_WRITE_INDEX = 8'h0c;
	localparam logic [7:0] ADDR_RX_READ_INDEX = 8'h10;
	localparam logic [7:0] ADDR_TX_READ_INDEX = 8'h14;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h18;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
	localparam logic [7:0] ADDR_RING_BASE = 8'h20;
	localparam logic [7:0] ADDR_RING_LAST = 8'h3c;

	// ========================================
	// field layouts
	localparam logic [7:0] PORT_ENABLE_BIT = 8'h01;
	localparam logic [7:0] STATUS_RUNNING = 8'h40;
	localparam logic [7:0] STATUS_RX_BUSY = 8'h08;
	localparam logic [7:0] STATUS_OVERFLOW = 8'h04;
	localparam logic [7:0] STATUS_FRAME_ERR = 8'h02;
	localparam logic [7:0] INDEX_MASK = 8'h07;
	localparam logic [3:0] RING_FULL_DISTANCE = 4'h7;
	localparam logic [2:0] INDEX_STEP = 3'h1;

	// interrupt event bits
	localparam int IRQ_W = 4;
	localparam logic [3:0] IRQ_START = 4'h1;
	localparam logic [3:0] IRQ_BYTE = 4'h2;
	localparam logic [3:0] IRQ_FRAME = 4'h4;
	localparam logic [3:0] IRQ_OVERFLOW = 4'h8;

	// receiver phases
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_SHIFT = 2'b01,
		RX_CHECK = 2'b10
	} rx_phase_type;

endpackage
`default_nettype wire

// ==== design/rx_line_sync.sv ====
`default_nettype none
// ========================================
// two-stage synchroniser for the serial input pin
module rx_line_sync (
	input wire logic mclk,
	input wire logic reset,
	input wire logic line_async,
	output logic line_sync
);
	import uart_rx_pkg::*;

	typedef struct packed {
		logic meta;
		logic stable;
	} sync_type;

	sync_type q, d;

	// first stage feeds only the second; line idles high
	always_comb begin
		d = q;
		d.meta = line_async;
		d.stable = q.meta;
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			q <= '{meta: 1'b1, stable: 1'b1};
		end else begin
			q <= d;
		end
	end

	assign line_sync = q.stable;

endmodule // rx_line_sync
`default_nettype wire

// ==== design/uart_receive_path.sv ====
// Chosen here: the Wishbone register port and the register addresses.
`default_nettype none
// What this block does
// [RULE1] idle low line starts a byte
// [RULE2] start sets receive-in-progress status flag
// [RULE3] first sample at one and half periods
// [RULE4] nine samples: eight data, then stop
// [RULE5] sample when due, lsb first, advance
// [RULE6] low stop bit: drop byte, frame flag
// [RULE7] eight-slot ring, indices masked modulo eight
// [RULE8] distance seven or more: drop, overflow flag
// [RULE9] store at write index, then advance it
// [RULE10] stored byte clears receive-in-progress flag
// [RULE11] disabled port clears state, write index and transmit read index
// [RULE12] bit period from sixteen-entry table
// [RULE13] enabled port keeps running flag set
// [RULE14] error flags hold until port disabled
module uart_receive_path (
	input wire logic mclk,
	input wire logic reset,
	input wire logic serial_input_line,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o
);
	import uart_rx_pkg::*;

	// ========================================
	// operating notes

	// bus side:
	// a request is taken on the edge where cyc and stb are high and ack is low
	// ack rises one cycle later and stands for one cycle only
	// read data is loaded as ack rises and holds until the next read
	// a write lands on the edge that ends the ack cycle
	// only lane zero carries data; a write with sel[0] low is ignored
	// unmapped reads return zero, unmapped writes do nothing
	// the master must drop cyc and stb for a cycle between requests

	// line side:
	// the pin passes two flops, so a start is seen two cycles late
	// that lag is the same for every bit, so sample spacing is unaffected
	// the start is only looked for while idle and enabled
	// samples fall at start plus half a period plus one period
	// each later sample is one period after the one before
	// nine samples in all: eight data bits, lsb first, then the stop bit
	// one cycle after the last sample the byte is stored or dropped
	// the next start can be seen from the cycle after that check

	// timing hazards:
	// the due test is a signed difference, so a timer wrap is harmless
	// this only holds while one and a half bit periods stay below half the timer range
	// a table entry of zero makes every cycle a sample cycle
	// that setting is meant for quick checks, not for a real line

	// ring hazards:
	// the host may write any read index; only the low three bits count
	// the device writes back only masked write indices
	// the full test is the plain distance of the two masked slots
	// so a distance of seven drops the byte, and one slot stays unused
	// a wrapped distance of one is not caught; software must keep up

	// status hazards:
	// on a frame error or an overflow the busy flag is left set
	// it is cleared by the next good byte or by turning the port off
	// error flags are sticky until the port is turned off
	// while off, status, write index and transmit read index read zero
	// the running flag returns on the first enabled cycle

	// interrupt hazards:
	// each event sets its sticky bit; writing a one clears it
	// an event in the same cycle as its clear wins
	// the interrupt line is a level, high while any unmasked bit is set

	// ========================================
	// state

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [7:0] port_command;
		logic [7:0] line_settings_byte;
		logic [7:0] serial_status_byte;
		logic [7:0] rx_write_index;
		logic [7:0] rx_read_index;
		logic [7:0] tx_read_index;
		logic [IRQ_W-1:0] irq_status;
		logic [IRQ_W-1:0] irq_mask;
		logic [7:0][7:0] rx_ring_storage;
		logic [TIMER_W-1:0] timer;
		logic [TIMER_W-1:0] sample_time;
		logic [BITS_PER_FRAME-1:0] shift_bits;
		logic [3:0] bits_left;
		rx_phase_type phase;
	} state_type;

	state_type q, d;
	logic line_level;

	// ========================================
	// pin synchroniser

	rx_line_sync line_sync_inst (
		.mclk(mclk),
		.reset(reset),
		.line_async(serial_input_line),
		.line_sync(line_level)
	);

	// ========================================
	// helpers

	// index as seen by the ring logic: low three bits only
	function automatic logic [2:0] ring_slot(input logic [7:0] index);
		ring_slot = 3'(index & INDEX_MASK); // RULE7
	endfunction

	// absolute distance between read and write slots
	function automatic logic [3:0] slot_distance(input logic [2:0] tail, input logic [2:0] head);
		logic [3:0] diff;
		diff = {1'b0, tail} - {1'b0, head};
		if (diff[3]) begin
			slot_distance = 4'(~diff + 4'h1);
		end else begin
			slot_distance = diff;
		end
	endfunction

	// true when the byte address hits one ring word
	function automatic logic ring_hit(input logic [7:0] addr);
		ring_hit = (addr >= ADDR_RING_BASE) && (addr <= ADDR_RING_LAST);
	endfunction

	// ========================================
	// combinational next state

	logic port_on;
	logic bus_write;
	logic sample_due;
	logic [TIMER_W-1:0] time_diff;
	logic [TIMER_W-1:0] bit_period;
	logic [2:0] head;
	logic [2:0] tail;
	logic [IRQ_W-1:0] events;
	logic [IRQ_W-1:0] irq_clear;

	always_comb begin
		d = q;
		events = '0;
		irq_clear = '0;
		port_on = (q.port_command & PORT_ENABLE_BIT) != 8'h00;
		bit_period = BIT_PERIOD_TABLE[q.line_settings_byte[3:0] & BAUD_SEL_MASK]; // RULE12
		time_diff = q.timer - q.sample_time;
		sample_due = ~time_diff[TIMER_W-1]; // RULE5
		head = ring_slot(q.rx_write_index); // RULE7
		tail = ring_slot(q.rx_read_index); // RULE7

		// free-running timer
		d.timer = q.timer + 32'h1;

		// wishbone: ack one cycle after the request, then drop
		d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
		bus_write = q.ack & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];

		// read data captured as ack rises; unmapped reads zero
		if (d.ack && !wb_we_i) begin
			d.rdata = '0;
			if (ring_hit(wb_adr_i)) begin
				d.rdata[7:0] = q.rx_ring_storage[wb_adr_i[4:2]];
			end else begin
				case (wb_adr_i)
					ADDR_PORT_COMMAND: d.rdata[7:0] = q.port_command;
					ADDR_LINE_SETTINGS: d.rdata[7:0] = q.line_settings_byte;
					ADDR_STATUS: d.rdata[7:0] = q.serial_status_byte;
					ADDR_RX_WRITE_INDEX: d.rdata[7:0] = q.rx_write_index;
					ADDR_RX_READ_INDEX: d.rdata[7:0] = q.rx_read_index;
					ADDR_TX_READ_INDEX: d.rdata[7:0] = q.tx_read_index;
					ADDR_IRQ_STATUS: d.rdata[IRQ_W-1:0] = q.irq_status;
					ADDR_IRQ_MASK: d.rdata[IRQ_W-1:0] = q.irq_mask;
					default: d.rdata = '0;
				endcase
			end
		end

		// software writes take effect at the acknowledged edge
		if (bus_write) begin
			case (wb_adr_i)
				ADDR_PORT_COMMAND: d.port_command = wb_dat_i[7:0];
				ADDR_LINE_SETTINGS: d.line_settings_byte = wb_dat_i[7:0];
				ADDR_RX_READ_INDEX: d.rx_read_index = wb_dat_i[7:0];
				ADDR_TX_READ_INDEX: d.tx_read_index = wb_dat_i[7:0];
				ADDR_IRQ_STATUS: irq_clear = wb_dat_i[IRQ_W-1:0];
				ADDR_IRQ_MASK: d.irq_mask = wb_dat_i[IRQ_W-1:0];
				default: d.irq_mask = q.irq_mask;
			endcase
		end

		// receiver
		if (!port_on) begin
			// cancel reception and clear shared bytes
			d.phase = RX_IDLE; // RULE11
			d.bits_left = 4'h0; // RULE11
			d.shift_bits = '0;
			d.serial_status_byte = 8'h00; // RULE11
			d.rx_write_index = 8'h00; // RULE11
			d.tx_read_index = 8'h00; // RULE11
		end else begin
			d.serial_status_byte = q.serial_status_byte | STATUS_RUNNING; // RULE13
			case (q.phase)
				RX_IDLE: begin
					if (!line_level) begin
						// start bit seen
						d.phase = RX_SHIFT; // RULE1
						d.serial_status_byte = d.serial_status_byte | STATUS_RX_BUSY; // RULE2
						d.sample_time = q.timer + (bit_period >> 1) + bit_period; // RULE3
						d.shift_bits = '0;
						d.bits_left = FRAME_COUNT; // RULE4
						events = events | IRQ_START;
					end
				end
				RX_SHIFT: begin
					if (sample_due) begin
						// lsb first: new bit enters at the top
						d.shift_bits = {line_level, q.shift_bits[BITS_PER_FRAME-1:1]}; // RULE5
						d.sample_time = q.sample_time + bit_period; // RULE5
						d.bits_left = q.bits_left - 4'h1;
						if (q.bits_left == 4'h1) begin
							d.phase = RX_CHECK; // RULE4
						end
					end
				end
				RX_CHECK: begin
					d.phase = RX_IDLE;
					d.bits_left = 4'h0;
					if (!q.shift_bits[BITS_PER_FRAME-1]) begin
						// stop bit low: byte dropped
						d.serial_status_byte = d.serial_status_byte | STATUS_FRAME_ERR; // RULE6
						events = events | IRQ_FRAME;
					end else if (slot_distance(tail, head) >= RING_FULL_DISTANCE) begin
						// ring too full: byte dropped
						d.serial_status_byte = d.serial_status_byte | STATUS_OVERFLOW; // RULE8
						events = events | IRQ_OVERFLOW;
					end else begin
						d.rx_ring_storage[head] = q.shift_bits[7:0]; // RULE9
						d.rx_write_index = {5'h00, 3'(head + INDEX_STEP)}; // RULE9
						// error bits are left as they stand
						d.serial_status_byte = d.serial_status_byte & ~STATUS_RX_BUSY; // RULE10 RULE14
						events = events | IRQ_BYTE;
					end
				end
				default: begin
					d.phase = RX_IDLE;
					d.bits_left = 4'h0;
				end
			endcase
		end

		// sticky interrupt bits: a new event beats a clear
		d.irq_status = (q.irq_status & ~irq_clear) | events;
	end

	// ========================================
	// registers

	always_ff @(posedge mclk) begin
		if (reset) begin
			q <= '0;
			q.phase <= RX_IDLE;
		end else begin
			q <= d;
		end
	end

	// ========================================
	// outputs

	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.rdata;
	assign irq_o = |(q.irq_status & q.irq_mask); // level while any unmasked bit is set

endmodule // uart_receive_path
`default_nettype wire

// ==== tb/uart_receive_path_properties.sv ====
`default_nettype none
// ========================================
// bus handshake and interrupt port checks
module uart_receive_path_properties (
	input wire logic mclk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic irq_o
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// a request, and its one-cycle answer
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_answer;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	property p_handshake; s_req |=> s_answer; endproperty
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i && !wb_ack_o); endproperty
	property p_idle_quiet; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
	property p_byte_lane; wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0; endproperty
	property p_dat_hold; $changed(wb_dat_o) |-> wb_ack_o && !wb_we_i; endproperty
	property p_release; $fell(reset) |-> !wb_ack_o && !irq_o; endproperty
	property p_irq_clear; $fell(irq_o) |-> $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2); endproperty
	a_handshake: assert property (p_handshake) else $error("ack not one cycle after request");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
	a_idle_quiet: assert property (p_idle_quiet) else $error("ack while idle");
	a_byte_lane: assert property (p_byte_lane) else $error("upper read bits not zero");
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved without read ack");
	a_release: assert property (p_release) else $error("outputs active after reset");
	a_irq_clear: assert property (p_irq_clear) else $error("irq dropped without a write");
endmodule // uart_receive_path_properties
bind uart_receive_path uart_receive_path_properties props (.mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
`default_nettype wire

// ==== tb/serial_tx_model.sv ====
`default_nettype none
// ========================================
// remote transmitter, one mclk per bit
module serial_tx_model (
	input wire logic mclk,
	output logic line
);
	timeunit 1ns;
	timeprecision 100ps;
	initial line = 1'h1;
	// start low, eight data lsb first, stop, then idle high
	task automatic send(input logic [7:0] data, input logic stop);
		logic [9:0] frame;
		frame = {stop, data, 1'h0};
		for (int i = 0; i < 10; i++) begin
			@(posedge mclk);
			line <= frame[i];
		end
		@(posedge mclk);
		line <= 1'h1;
		repeat (6) @(posedge mclk);
	endtask
endmodule // serial_tx_model
`default_nettype wire

// ==== tb/uart_receive_path_tb.sv ====
`default_nettype none
module uart_receive_path_tb import uart_rx_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [7:0] data; logic [7:0] index;} row_type;
	logic mclk, reset, cyc, stb, we, ack, irq, line;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdata, rdata;
	int fail_count, total_checks;
	row_type rows [7] = '{'{8'h55, 8'h01}, '{8'h00, 8'h02}, '{8'hff, 8'h03}, '{8'ha3, 8'h04},
		'{8'h01, 8'h05}, '{8'h80, 8'h06}, '{8'h3c, 8'h07}};
	uart_receive_path DUT (.mclk(mclk), .reset(reset), .serial_input_line(line), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdata), .wb_dat_o(rdata), .wb_ack_o(ack), .irq_o(irq));
	serial_tx_model far_end (.mclk(mclk), .line(line));
	// ========================================
	// helpers
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
		@(posedge mclk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdata <= {24'h0, d};
		do @(posedge mclk); while (ack !== 1'h1);
		q = rdata;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] q;
		bus(1'h0, a, 8'h00, q);
		chk(q, {24'h0, e});
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'h1, a, d, q);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// ========================================
	// clock and watchdog
	initial begin
		mclk = 1'h0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		fail_count++;
		tally_and_finish();
	end
	// ========================================
	// main sequence
	initial begin
		reset = 1'h1;
		{cyc, stb, we, adr, wdata} = '0;
		sel = 4'h1;
		repeat (8) @(posedge mclk);
		reset <= 1'h0;
		rd(ADDR_STATUS, 8'h00);
		rd(8'h80, 8'h00);
		wr(ADDR_LINE_SETTINGS, 8'h00);
		wr(ADDR_PORT_COMMAND, PORT_ENABLE_BIT);
		wr(ADDR_TX_READ_INDEX, 8'h05);
		wr(ADDR_IRQ_MASK, {4'h0, IRQ_FRAME});
		rd(ADDR_STATUS, STATUS_RUNNING);
		// good bytes fill the ring to seven entries
		for (int i = 0; i < 7; i++) begin
			far_end.send(rows[i].data, 1'h1);
			rd(ADDR_RING_BASE + 8'(4 * i), rows[i].data);
			rd(ADDR_RX_WRITE_INDEX, rows[i].index);
			rd(ADDR_STATUS, STATUS_RUNNING);
		end
		far_end.send(8'h99, 1'h1);
		rd(ADDR_RX_WRITE_INDEX, 8'h07);
		rd(ADDR_STATUS, 8'h4c);
		chk({31'h0, irq}, 32'h0);
		// host index beyond seven is masked, ring wraps
		wr(ADDR_RX_READ_INDEX, 8'h0f);
		far_end.send(8'h6e, 1'h1);
		rd(ADDR_RING_LAST, 8'h6e);
		rd(ADDR_RX_WRITE_INDEX, 8'h00);
		rd(ADDR_STATUS, 8'h44);
		far_end.send(8'h12, 1'h0);
		rd(ADDR_RX_WRITE_INDEX, 8'h00);
		rd(ADDR_RING_BASE, 8'h55);
		rd(ADDR_STATUS, 8'h4e);
		chk({31'h0, irq}, 32'h1);
		wr(ADDR_IRQ_STATUS, {4'h0, IRQ_FRAME});
		repeat (2) @(posedge mclk);
		chk({31'h0, irq}, 32'h0);
		rd(ADDR_IRQ_STATUS, 8'h0b);
		wr(ADDR_RX_READ_INDEX, 8'h00);
		far_end.send(8'h21, 1'h1);
		rd(ADDR_RING_BASE, 8'h21);
		rd(ADDR_STATUS, 8'h46);
		// disabling clears state and ignores the line
		wr(ADDR_PORT_COMMAND, 8'h00);
		rd(ADDR_RX_WRITE_INDEX, 8'h00);
		rd(ADDR_TX_READ_INDEX, 8'h00);
		far_end.send(8'h33, 1'h1);
		rd(ADDR_STATUS, 8'h00);
		tally_and_finish();
	end
endmodule // uart_receive_path_tb
`default_nettype wire
